// >>> rtl/msf_config.sv
// Motor sense filter configuration: APB registers, zc filter, blanking, capture
//
// What this block does
// - Edge select 00 means position sensor or sensorless mode, not speed sensor.
// - Edge codes 01 rise, 10 fall, 11 both; each selects speed sensor mode.
// - Polarity bit 0 gives active-high channel, 1 gives active-low channel.
// - Polarity bits are ignored while independent phases is set.
// - Zc event needs count field plus one consecutive valid samples.
// - Zc samples come at sampling clock rate or at PWM rate.
// - Each demag event in sensorless mode with zc sampling enabled starts a blanking window that hides zc detection.
// - Sensorless window 5..40 us step 5, then 60..200 us step 20; none with sensors.
// - Sampling valid bit gates zc sampling while main output enable is low.
// - Sampling clock is 1 MHz, 500, 250 or 125 kHz for codes 00..11.
// - Encoder capture on real-time tick, or on timer high byte read.
// - Unused inputs grounded or high-Z only with phases 0, edges 00, sensorless.
// - Reset: tacho/polarity and sampling registers 00, filter register 0F.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module msf_config
  import msf_pkg::*;
#(
  parameter int CLK_KHZ = MSF_CLK_KHZ,
  parameter int TIMER_WIDTH = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic demag_in,
  input wire logic zc_in,
  input wire logic tacho_in,
  input wire logic pwm_sample,
  input wire logic rtc_tick,
  input wire logic timer_high_byte_read,
  input wire logic [TIMER_WIDTH-1:0] timer_value,
  input wire logic [5:0] phase_drive,
  output logic [5:0] phase_out,
  output logic zc_event,
  output logic blanking,
  output logic speed_sensor_mode,
  output logic tacho_capture,
  output logic [TIMER_WIDTH-1:0] timer_capture,
  output logic unused_ground,
  output logic unused_hiz
);
  localparam int BW = 12;
  localparam int SAMPLE_DIV = MSF_SAMPLE_BASE_NS * CLK_KHZ / 1000000;

  initial
  begin
    if (CLK_KHZ < 2000 || CLK_KHZ > 10000)
    begin
      $error("CLK_KHZ outside 2000..10000");
    end
    if (TIMER_WIDTH < 1 || TIMER_WIDTH > 16)
    begin
      $error("TIMER_WIDTH outside 1..16");
    end
  end

  // Window length in clock cycles for a window code
  function automatic logic [BW-1:0] blank_cycles(input logic [3:0] code);
    logic [47:0] ns;
    logic [47:0] cyc;
    ns = 48'(MSF_BLANK_STEP_LO_NS) * 48'(code + 4'h1);
    if (code[3])
    begin
      ns = 48'(MSF_BLANK_BASE_HI_NS) + 48'(MSF_BLANK_STEP_HI_NS) * 48'(code[2:0]);
    end
    cyc = ns * 48'(CLK_KHZ) / 48'd1000000;
    blank_cycles = BW'(cyc);
  endfunction : blank_cycles

  // Byte decode shared by read and write paths
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    case (addr)
      MSF_OFS_TACHO_POL: reg_index = 3'h0;
      MSF_OFS_ZC_FILTER: reg_index = 3'h1;
      MSF_OFS_SAMPLE_CTRL: reg_index = 3'h2;
      MSF_OFS_MODE_CTRL: reg_index = 3'h3;
      MSF_OFS_STATUS: reg_index = 3'h4;
      default: reg_index = 3'h7;
    endcase
  endfunction : reg_index

  logic [7:0] tacho_and_polarity;
  logic [7:0] zero_cross_filter;
  logic [7:0] sampling_clock_ctrl;
  logic [3:0] mode_ctrl;
  msf_cfg_t cfg;
  msf_state_t state;
  msf_state_t next_state;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic demag_q;
  logic tacho_q;
  logic demag_rise;
  logic tacho_rise;
  logic tacho_fall;
  logic sample_tick;
  logic sample_strobe;
  logic sample_en;
  logic blank_busy;
  logic blank_load;
  logic [4:0] zc_count;
  logic [4:0] zc_target;
  logic wr_access;
  logic setup;
  logic [2:0] idx;

  // APB decode
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign idx = reg_index(paddr);
  assign pready = 1'b1;

  // Configuration view of the registers
  always_comb
  begin
    cfg.tacho_edge_sel = tacho_and_polarity[MSF_TES_LSB +: 2];
    cfg.polarity = tacho_and_polarity[5:0];
    cfg.zc_event_count = zero_cross_filter[MSF_ZEF_LSB +: 4];
    cfg.zc_blank_window = zero_cross_filter[3:0];
    cfg.zc_sampling_valid = sampling_clock_ctrl[MSF_ZSV_BIT];
    cfg.sample_clock_sel = sampling_clock_ctrl[MSF_SCF_LSB +: 2];
    cfg.encoder_capture_src = sampling_clock_ctrl[MSF_ECM_BIT];
    cfg.unused_input_hiz = sampling_clock_ctrl[MSF_HIZ_BIT];
    cfg.sensor_select = mode_ctrl[MSF_MODE_SENSOR_BIT];
    cfg.independent_phases = mode_ctrl[MSF_MODE_INDEP_BIT];
    cfg.main_output_enable = mode_ctrl[MSF_MODE_MOE_BIT];
    cfg.zc_sample_at_pwm = mode_ctrl[MSF_MODE_PWM_BIT];
  end

  // Register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tacho_and_polarity <= MSF_RST_TACHO_POL;
      zero_cross_filter <= MSF_RST_ZC_FILTER;
      sampling_clock_ctrl <= MSF_RST_SAMPLE_CTRL;
      mode_ctrl <= MSF_RST_MODE_CTRL;
    end
    else if (wr_access)
    begin
      case (idx)
        3'h0: tacho_and_polarity <= pwdata[7:0];
        3'h1: zero_cross_filter <= pwdata[7:0];
        // Reserved bits are forced low so a careless write cannot set them
        3'h2: sampling_clock_ctrl <= pwdata[7:0] & MSF_MASK_SAMPLE_CTRL;
        3'h3: mode_ctrl <= pwdata[3:0];
        default: mode_ctrl <= mode_ctrl;
      endcase
    end
  end

  // Read data and error are captured in setup so the access needs no wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= (idx == 3'h7);
      case (idx)
        3'h0: prdata <= {24'h0, tacho_and_polarity};
        3'h1: prdata <= {24'h0, zero_cross_filter};
        3'h2: prdata <= {24'h0, sampling_clock_ctrl};
        3'h3: prdata <= {28'h0, mode_ctrl};
        3'h4: prdata <= {16'(timer_capture), 7'h0, zc_count, blank_busy,
                         speed_sensor_mode, 2'(state)};
        default: prdata <= '0;
      endcase
    end
  end

  // Comparator and tacho pins cross in through two flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= {tacho_in, zc_in, demag_in};
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      demag_q <= 1'b0;
      tacho_q <= 1'b0;
    end
    else
    begin
      demag_q <= sync_b[0];
      tacho_q <= sync_b[2];
    end
  end

  assign demag_rise = sync_b[0] && !demag_q;
  assign tacho_rise = sync_b[2] && !tacho_q;
  assign tacho_fall = !sync_b[2] && tacho_q;

  // Tacho edge sensitivity and operating mode
  assign speed_sensor_mode = (cfg.tacho_edge_sel != MSF_TES_NONE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tacho_capture <= 1'b0;
    end
    else
    begin
      case (cfg.tacho_edge_sel)
        MSF_TES_RISE: tacho_capture <= tacho_rise;
        MSF_TES_FALL: tacho_capture <= tacho_fall;
        MSF_TES_BOTH: tacho_capture <= tacho_rise || tacho_fall;
        default: tacho_capture <= 1'b0;
      endcase
    end
  end

  // Encoder timer capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_capture <= '0;
    end
    else if (speed_sensor_mode)
    begin
      if (cfg.encoder_capture_src ? timer_high_byte_read : rtc_tick)
      begin
        timer_capture <= timer_value;
      end
    end
  end

  // Output polarity, bypassed for three independent phases
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_out <= '0;
    end
    else if (cfg.independent_phases)
    begin
      phase_out <= phase_drive;
    end
    else
    begin
      phase_out <= phase_drive ^ cfg.polarity;
    end
  end

  // Unused phase input handling
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unused_ground <= 1'b0;
      unused_hiz <= 1'b0;
    end
    else
    begin
      unused_ground <= !cfg.independent_phases && !speed_sensor_mode
                       && !cfg.sensor_select && !cfg.unused_input_hiz;
      unused_hiz <= !cfg.independent_phases && !speed_sensor_mode
                    && !cfg.sensor_select && cfg.unused_input_hiz;
    end
  end

  msf_sample_div #(
    .BASE_DIV(SAMPLE_DIV)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .sample_clock_sel(cfg.sample_clock_sel),
    .sample_tick(sample_tick)
  );

  // Sample source and enable; a running output stage always samples
  assign sample_strobe = cfg.zc_sample_at_pwm ? pwm_sample : sample_tick;
  assign sample_en = cfg.main_output_enable || cfg.zc_sampling_valid;

  // Sensors need no window, so the timer is only loaded when sensorless
  assign blank_load = demag_rise && sample_en && !cfg.sensor_select;

  msf_blank_timer #(
    .WIDTH(BW)
  ) u_blank (
    .pclk(pclk),
    .presetn(presetn),
    .load(blank_load),
    .load_value(blank_cycles(cfg.zc_blank_window)),
    .busy(blank_busy)
  );

  assign blanking = blank_busy || (state == MSF_BLANK);
  assign zc_target = {1'b0, cfg.zc_event_count} + 5'h1;

  // Filter sequencing: blank, count, then hold until the next demag
  always_comb
  begin
    next_state = state;
    case (state)
      MSF_IDLE:
      begin
        if (sample_en)
        begin
          next_state = MSF_COUNT;
        end
      end
      MSF_BLANK:
      begin
        if (!blank_busy)
        begin
          next_state = MSF_COUNT;
        end
      end
      MSF_COUNT:
      begin
        if (sample_strobe && sync_b[1] && (zc_count + 5'h1 >= zc_target))
        begin
          next_state = MSF_DONE;
        end
      end
      MSF_DONE:
      begin
        next_state = MSF_DONE;
      end
      default: next_state = MSF_IDLE;
    endcase
    if (!sample_en)
    begin
      next_state = MSF_IDLE;
    end
    else if (demag_rise)
    begin
      next_state = cfg.sensor_select ? MSF_COUNT : MSF_BLANK;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= MSF_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Consecutive sample counter; a low sample breaks the run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      zc_count <= '0;
    end
    else if (state != MSF_COUNT || demag_rise)
    begin
      zc_count <= '0;
    end
    else if (sample_strobe)
    begin
      zc_count <= sync_b[1] ? zc_count + 5'h1 : 5'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      zc_event <= 1'b0;
    end
    else
    begin
      zc_event <= (state == MSF_COUNT) && (next_state == MSF_DONE);
    end
  end
endmodule : msf_config

// >>> shared/msf_pkg.sv
// Shared constants and types for the motor sense filter configuration block
package msf_pkg;
  // Register byte offsets
  localparam logic [7:0] MSF_OFS_TACHO_POL = 8'h00;
  localparam logic [7:0] MSF_OFS_ZC_FILTER = 8'h04;
  localparam logic [7:0] MSF_OFS_SAMPLE_CTRL = 8'h08;
  localparam logic [7:0] MSF_OFS_MODE_CTRL = 8'h0c;
  localparam logic [7:0] MSF_OFS_STATUS = 8'h10;
  // Reset values
  localparam logic [7:0] MSF_RST_TACHO_POL = 8'h00;
  localparam logic [7:0] MSF_RST_ZC_FILTER = 8'h0f;
  localparam logic [7:0] MSF_RST_SAMPLE_CTRL = 8'h00;
  localparam logic [3:0] MSF_RST_MODE_CTRL = 4'h0;
  // Writable bit masks; sampling control bits 6:4 stay zero
  localparam logic [7:0] MSF_MASK_SAMPLE_CTRL = 8'h8f;
  // Field positions
  localparam int MSF_TES_LSB = 6;
  localparam int MSF_ZEF_LSB = 4;
  localparam int MSF_ZSV_BIT = 7;
  localparam int MSF_SCF_LSB = 2;
  localparam int MSF_ECM_BIT = 1;
  localparam int MSF_HIZ_BIT = 0;
  localparam int MSF_MODE_SENSOR_BIT = 0;
  localparam int MSF_MODE_INDEP_BIT = 1;
  localparam int MSF_MODE_MOE_BIT = 2;
  localparam int MSF_MODE_PWM_BIT = 3;
  // Tacho edge codes
  localparam logic [1:0] MSF_TES_NONE = 2'h0;
  localparam logic [1:0] MSF_TES_RISE = 2'h1;
  localparam logic [1:0] MSF_TES_FALL = 2'h2;
  localparam logic [1:0] MSF_TES_BOTH = 2'h3;
  // Timing, in ns, as printed for the window and sampling tables; then the clock in kHz and the base divide in cycles
  localparam int MSF_BLANK_STEP_LO_NS = 5000;
  localparam int MSF_BLANK_BASE_HI_NS = 60000;
  localparam int MSF_BLANK_STEP_HI_NS = 20000;
  localparam int MSF_SAMPLE_BASE_NS = 1000;
  localparam int MSF_CLK_KHZ = 10000;
  localparam int MSF_SAMPLE_BASE_DIV = MSF_SAMPLE_BASE_NS * MSF_CLK_KHZ / 1000000;

  typedef struct packed {
    logic [1:0] tacho_edge_sel;
    logic [5:0] polarity;
    logic [3:0] zc_event_count;
    logic [3:0] zc_blank_window;
    logic zc_sampling_valid;
    logic [1:0] sample_clock_sel;
    logic encoder_capture_src;
    logic unused_input_hiz;
    logic sensor_select;
    logic independent_phases;
    logic main_output_enable;
    logic zc_sample_at_pwm;
  } msf_cfg_t;

  typedef enum logic [1:0] {
    MSF_IDLE = 2'h0,
    MSF_BLANK = 2'h1,
    MSF_COUNT = 2'h3,
    MSF_DONE = 2'h2
  } msf_state_t;
endpackage : msf_pkg

// >>> rtl/msf_sample_div.sv
// Sampling clock divider producing one-cycle enable pulses
`timescale 1ns/1ps
module msf_sample_div
  import msf_pkg::*;
#(
  parameter int BASE_DIV = MSF_SAMPLE_BASE_DIV
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] sample_clock_sel,
  output logic sample_tick
);
  localparam int CW = $clog2(BASE_DIV * 8 + 1);
  logic [CW-1:0] count;
  logic [CW-1:0] period;

  initial
  begin
    if (BASE_DIV < 2)
    begin
      $error("BASE_DIV must be at least 2");
    end
  end

  // Period doubles with each step of the select code
  assign period = CW'(BASE_DIV << sample_clock_sel);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= '0;
      sample_tick <= 1'b0;
    end
    else if (count >= period - CW'(1))
    begin
      count <= '0;
      sample_tick <= 1'b1;
    end
    else
    begin
      count <= count + CW'(1);
      sample_tick <= 1'b0;
    end
  end
endmodule : msf_sample_div

// >>> rtl/msf_blank_timer.sv
// Loadable down counter timing the blanking window after a demag event
`timescale 1ns/1ps
module msf_blank_timer
#(
  parameter int WIDTH = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic busy
);
  logic [WIDTH-1:0] remain;

  initial
  begin
    if (WIDTH < 2)
    begin
      $error("WIDTH must be at least 2");
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      remain <= '0;
    end
    else if (load)
    begin
      remain <= load_value;
    end
    else if (remain != '0)
    begin
      remain <= remain - WIDTH'(1);
    end
  end

  assign busy = (remain != '0);
endmodule : msf_blank_timer

// >>> tb/msf_config_assertions.sv
// Checker for the motor sense filter configuration block
`timescale 1ns/1ps
module msf_config_assertions
  import msf_pkg::*;
#(
  parameter int TIMER_WIDTH = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic rtc_tick,
  input wire logic timer_high_byte_read,
  input wire logic [TIMER_WIDTH-1:0] timer_value,
  input wire logic [5:0] phase_drive,
  input wire logic [5:0] phase_out,
  input wire logic zc_event,
  input wire logic blanking,
  input wire logic speed_sensor_mode,
  input wire logic tacho_capture,
  input wire logic [TIMER_WIDTH-1:0] timer_capture,
  input wire logic unused_ground,
  input wire logic unused_hiz
);
  logic eff;
  logic off;
  logic off_d;
  logic trig;
  logic [1:0] gh;
  logic [5:0] ph_exp;
  logic [7:0] par;
  logic [7:0] scr;
  logic [3:0] mode;
  // Mirror of written fields, updated at the same edge as the registers
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      par <= MSF_RST_TACHO_POL;
      scr <= MSF_RST_SAMPLE_CTRL;
      mode <= MSF_RST_MODE_CTRL;
    end
    else if (psel && penable && pwrite)
    begin
      if (paddr == MSF_OFS_TACHO_POL)
        par <= pwdata[7:0];
      if (paddr == MSF_OFS_SAMPLE_CTRL)
        scr <= pwdata[7:0];
      if (paddr == MSF_OFS_MODE_CTRL)
        mode <= pwdata[3:0];
    end
  // One cycle of margin so a pending sample cannot be blamed on the gate
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      off_d <= 1'b0;
    else
      off_d <= off;
  assign off = !mode[2] && !scr[7];
  assign eff = !mode[1] && par[7:6] == 2'h0 && !mode[0];
  assign gh = {eff && !scr[0], eff && scr[0]};
  assign ph_exp = mode[1] ? phase_drive : phase_drive ^ par[5:0];
  assign trig = scr[1] ? timer_high_byte_read : rtc_tick;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_blank_start;
    $rose(blanking) && !mode[0];
  endsequence
  sequence s_blank_hold;
    blanking[*8];
  endsequence
  a_speed_mode: assert property (speed_sensor_mode == (par[7:6] != 2'h0))
    else $error("speed mode wrong");
  a_tacho_idle: assert property (!speed_sensor_mode && !$past(speed_sensor_mode) |-> !tacho_capture)
    else $error("tacho capture outside speed mode");
  a_zc_single: assert property (zc_event |=> !zc_event)
    else $error("zc event longer than one cycle");
  a_zc_blanked: assert property (blanking && $past(blanking) |-> !zc_event)
    else $error("zc event during blanking");
  a_blank_hold: assert property (s_blank_start |-> s_blank_hold)
    else $error("blanking window too short");
  a_phase_map: assert property ($past(presetn) |-> phase_out == $past(ph_exp))
    else $error("phase output polarity wrong");
  a_capture_src: assert property (speed_sensor_mode && trig |=> timer_capture == $past(timer_value))
    else $error("timer capture wrong");
  a_unused_sel: assert property ($past(presetn) |-> {unused_ground, unused_hiz} == $past(gh))
    else $error("unused input handling wrong");
  a_sampling_off: assert property (off && off_d |-> !zc_event)
    else $error("zc event with sampling disabled");
endmodule : msf_config_assertions

bind msf_config msf_config_assertions #(.TIMER_WIDTH(TIMER_WIDTH)) msf_config_assertions_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .rtc_tick(rtc_tick),
  .timer_high_byte_read(timer_high_byte_read), .timer_value(timer_value),
  .phase_drive(phase_drive), .phase_out(phase_out), .zc_event(zc_event),
  .blanking(blanking), .speed_sensor_mode(speed_sensor_mode), .tacho_capture(tacho_capture),
  .timer_capture(timer_capture), .unused_ground(unused_ground), .unused_hiz(unused_hiz));

// >>> tb/msf_partner.sv
// Model of the motor power stage and position sensors
`timescale 1ns/1ps
module msf_partner
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic kick,
  input wire logic zc_on,
  output logic demag_in,
  output logic zc_in,
  output logic tacho_in,
  output logic rtc_tick,
  output logic [15:0] timer_value
);
  logic [2:0] dcnt;
  // Demag held several cycles so the input synchroniser cannot miss it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      dcnt <= 3'h0;
    else if (kick)
      dcnt <= 3'h6;
    else if (dcnt != 3'h0)
      dcnt <= dcnt - 3'h1;
  // Shaft timer runs free; tacho and real-time tick derive from it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      timer_value <= 16'h0;
    else
      timer_value <= timer_value + 16'h1;
  assign demag_in = dcnt != 3'h0;
  assign zc_in = zc_on;
  assign tacho_in = timer_value[4];
  assign rtc_tick = timer_value[4:0] == 5'h1f;
endmodule : msf_partner

// >>> tb/msf_config_tb_top.sv
// Testbench top for the motor sense filter configuration block
`timescale 1ns/1ps
module msf_config_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, kick, zc_on;
  logic demag_in, zc_in, tacho_in, pwm_sample, rtc_tick, hb_rd, zc_event, blanking;
  logic speed_sensor_mode, tacho_capture, unused_ground, unused_hiz;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] timer_value, timer_capture;
  logic [5:0] phase_drive, phase_out;
  logic [32:0] q[$];
  int failures = 0;
  int checks = 0;
  int zc_seen = 0;
  int tc_seen = 0;

  msf_config msf_config_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .demag_in(demag_in), .zc_in(zc_in),
    .tacho_in(tacho_in), .pwm_sample(pwm_sample), .rtc_tick(rtc_tick),
    .timer_high_byte_read(hb_rd), .timer_value(timer_value), .phase_drive(phase_drive),
    .phase_out(phase_out), .zc_event(zc_event), .blanking(blanking),
    .speed_sensor_mode(speed_sensor_mode), .tacho_capture(tacho_capture),
    .timer_capture(timer_capture), .unused_ground(unused_ground), .unused_hiz(unused_hiz));
  msf_partner msf_partner_inst (.pclk(pclk), .presetn(presetn), .kick(kick), .zc_on(zc_on),
    .demag_in(demag_in), .zc_in(zc_in), .tacho_in(tacho_in), .rtc_tick(rtc_tick),
    .timer_value(timer_value));

  // 10 MHz, the rate all window and sample counts are derived
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("Checks %0d, failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  always @(posedge pclk)
  begin
    zc_seen <= zc_seen + (zc_event === 1'b1);
    tc_seen <= tc_seen + (tacho_capture === 1'b1);
    if (psel && penable && pready && !pwrite)
      check("read", {pslverr, prdata}, q.pop_front());
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      failures++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic kick_demag();
    kick <= 1'b1;
    @(posedge pclk);
    kick <= 1'b0;
  endtask : kick_demag

  // Waits for blanking high (0), blanking low (1), a zc event (2) or an rtc tick (3)
  task automatic wait_on(input int w, input int lim, output int n);
    logic hit;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
      hit = w == 0 ? blanking === 1'b1 : w == 1 ? blanking === 1'b0 :
        w == 2 ? zc_event === 1'b1 : rtc_tick === 1'b1;
    end
    while (!hit && n < lim);
    if (!hit)
    begin
      failures++;
      conclude();
    end
  endtask : wait_on

  initial
  begin
    int n;
    int lo;
    logic [3:0] k;
    logic [7:0] v;
    {psel, penable, pwrite, pwm_sample, hb_rd, kick, presetn} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    phase_drive = 6'h0;
    zc_on = 1'b1;
    void'($urandom(86));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, 33'h0);
    rd(8'h04, 33'h0f);
    rd(8'h08, 33'h0);
    rd(8'h40, 33'h100000000);
    // Reserved bits set on purpose; they must read back clear
    wr(8'h08, 32'hff);
    rd(8'h08, 33'h8f);
    v = 8'($urandom);
    wr(8'h04, {24'h0, v});
    rd(8'h04, {25'h0, v});
    $display("Test registers finished");
    repeat (2)
    begin
      phase_drive <= 6'($urandom);
      v = 8'($urandom);
      wr(8'h0c, 32'h0);
      wr(8'h00, {26'h0, v[5:0]});
      @(posedge pclk);
      check("phase", phase_out, phase_drive ^ v[5:0]);
      wr(8'h0c, 32'h2);
      @(posedge pclk);
      check("phase indep", phase_out, phase_drive);
    end
    $display("Test polarity finished");
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h00, 32'(s << 6));
      check("speed mode", speed_sensor_mode, s != 0);
      repeat (10) @(posedge pclk);
      n = tc_seen;
      repeat (320) @(posedge pclk);
      check("tacho", 33'(tc_seen - n), s == 3 ? 20 : s == 0 ? 0 : 10);
    end
    wr(8'h08, 32'h2);
    hb_rd <= 1'b1;
    @(posedge pclk);
    v = timer_value[7:0];
    lo = timer_value;
    hb_rd <= 1'b0;
    @(posedge pclk);
    check("capture", timer_capture, 33'(lo));
    wr(8'h08, 32'h0);
    wait_on(3, 40, n);
    lo = timer_value;
    @(posedge pclk);
    check("rtc capture", timer_capture, 33'(lo));
    // Back to the idle high-byte source so the capture holds during the reads
    wr(8'h08, 32'h2);
    rd(8'h0c, 33'h2);
    rd(8'h10, {1'b0, 16'(lo), 16'h0004});
    wr(8'h00, 32'h0);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h0c, 32'(c[1]));
      wr(8'h08, 32'(c[0]));
      @(posedge pclk);
      check("unused", {unused_ground, unused_hiz}, {!c[1] && !c[0], !c[1] && c[0]});
    end
    $display("Test tacho capture inputs finished");
    wr(8'h0c, 32'h4);
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h04, 32'(c));
      // 5 us steps then 20 us steps, in 100 ns cycles
      lo = c < 8 ? 50 * (c + 1) : 600 + 200 * (c - 8);
      kick_demag();
      wait_on(0, 20, n);
      wait_on(1, 2100, n);
      check("blank", n >= lo - 1 && n <= lo + 2, 1'b1);
    end
    wr(8'h0c, 32'h5);
    kick_demag();
    n = 0;
    repeat (20)
    begin
      @(posedge pclk);
      n += (blanking === 1'b1);
    end
    check("no window", 33'(n), 33'h0);
    $display("Test blanking finished");
    for (int c = 0; c < 3; c++)
    begin
      k = 4'($urandom_range(15, 0));
      wr(8'h0c, c == 0 ? 32'hc : 32'h8);
      wr(8'h08, c == 2 ? 32'h80 : 32'h0);
      wr(8'h04, {24'h0, k, 4'h0});
      kick_demag();
      repeat (70) @(posedge pclk);
      n = zc_seen;
      for (int i = 0; i <= k; i++)
      begin
        if (i == k)
          check("early zc", 33'(zc_seen - n), 33'h0);
        pwm_sample <= 1'b1;
        @(posedge pclk);
        pwm_sample <= 1'b0;
        repeat (3) @(posedge pclk);
      end
      check("zc event", 33'(zc_seen - n), c != 1);
    end
    wr(8'h0c, 32'h4);
    wr(8'h04, 32'hf0);
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h08, 32'(s << 2));
      kick_demag();
      wait_on(0, 20, n);
      wait_on(1, 100, n);
      wait_on(2, 2000, n);
      lo = 150 << s;
      check("rate", n >= lo && n <= lo + (10 << s) + 3, 1'b1);
    end
    $display("Test zc filter finished");
    conclude();
  end
endmodule : msf_config_tb_top
